//--- arith_shift_alu8_pkg.sv
// Constants, operation codes and operand forms of the eight-bit arithmetic and shift datapath
package arith_shift_alu8_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int DATA_W   = 8;
  localparam int NIBBLE_W = 4;
  localparam int FLAG_W   = 4;

  // ==========================================================================
  // Flag vector bit positions (flag_load_data layout)
  // ==========================================================================
  localparam int FLAG_Z_POS   = 0;
  localparam int FLAG_C_POS   = 1;
  localparam int FLAG_NIB_POS = 2;
  localparam int FLAG_RNG_POS = 3;

  // ==========================================================================
  // Reset values and fixed operands
  // ==========================================================================
  localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 4'h0;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;

  // ==========================================================================
  // Operation codes
  // ==========================================================================
  typedef enum logic [3:0] {
    OP_NOP   = 4'b0000,
    OP_ADD   = 4'b0001,
    OP_ADDC  = 4'b0010,
    OP_NADD  = 4'b0011,
    OP_SUB   = 4'b0100,
    OP_SUBC  = 4'b0101,
    OP_INC   = 4'b0110,
    OP_DEC   = 4'b0111,
    OP_CLEAR = 4'b1000,
    OP_SHR   = 4'b1001,
    OP_SRC   = 4'b1010,
    OP_SHL   = 4'b1011,
    OP_SLC   = 4'b1100,
    OP_SWAP  = 4'b1101
  } alu_op_e;

  // ==========================================================================
  // Operand forms: first letter is the destination
  // ==========================================================================
  typedef enum logic [2:0] {
    FORM_A_I = 3'b000,
    FORM_A_M = 3'b001,
    FORM_M_A = 3'b010,
    FORM_A   = 3'b011,
    FORM_M   = 3'b100
  } alu_form_e;

endpackage

//--- ripple_add8.sv
// Eight-bit ripple adder with carry, nibble carry and signed overflow outputs
`timescale 1ns/1ps

module ripple_add8
  import arith_shift_alu8_pkg::*;
(
  input  wire logic [DATA_W-1:0] add_a,
  input  wire logic [DATA_W-1:0] add_b,
  input  wire logic              add_cin,
  output logic      [DATA_W-1:0] add_sum,
  output logic                   add_cout,
  output logic                   add_nibble_cout,
  output logic                   add_overflow
);

  logic [DATA_W:0] carry;

  assign carry[0] = add_cin;

  // ==========================================================================
  // Full-adder chain
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < DATA_W; i = i + 1)
    begin : g_bit
      assign add_sum[i]   = add_a[i] ^ add_b[i] ^ carry[i];
      assign carry[i + 1] = (add_a[i] & add_b[i]) | (carry[i] & (add_a[i] ^ add_b[i]));
    end
  endgenerate

  assign add_cout        = carry[DATA_W];
  assign add_nibble_cout = carry[NIBBLE_W];
  // Signed overflow when carries into and out of the sign bit differ
  assign add_overflow    = carry[DATA_W] ^ carry[DATA_W-1];

endmodule

//--- arith_shift_alu8.sv
// Eight-bit arithmetic and shift datapath with working register and four flags
`timescale 1ns/1ps

// Function
// - Add immediate to working register, flags updated
// - Add memory byte, result to register or memory
// - Add register, memory and ripple bit
// - Add ripple bit alone to one operand
// - Register gets memory minus register
// - Memory gets register minus memory
// - Subtract immediate from working register
// - Subtract memory byte from working register
// - Memory gets memory minus working register
// - Register minus memory minus ripple bit
// - Memory minus register minus ripple bit
// - Subtract ripple bit alone from one operand
// - Increment memory byte, flags updated
// - Decrement memory byte, flags updated
// - Clear memory byte, flags untouched
// - Logical right shift, bit 0 to ripple
// - Rotate right through ripple bit
// - Logical left shift, bit 7 to ripple
// - Rotate left through ripple bit
// - Swap register nibbles, flags untouched
// - Ripple flag means borrow on subtraction
module arith_shift_alu8
  import arith_shift_alu8_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              op_valid,
  input  wire alu_op_e           op_code,
  input  wire alu_form_e         op_form,
  input  wire logic [DATA_W-1:0] imm_data,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  input  wire logic              wreg_load,
  input  wire logic [DATA_W-1:0] wreg_load_data,
  input  wire logic              flag_load,
  input  wire logic [FLAG_W-1:0] flag_load_data,
  output logic      [DATA_W-1:0] working_register_q,
  output logic                   zero_flag_q,
  output logic                   ripple_flag_q,
  output logic                   nibble_ripple_flag_q,
  output logic                   signed_range_flag_q,
  output logic                   mem_wr_en_q,
  output logic      [DATA_W-1:0] mem_wr_data_q,
  output logic                   op_done_q
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic op_is_sub(input alu_op_e op);
    op_is_sub = (op == OP_SUB) || (op == OP_SUBC) || (op == OP_NADD) || (op == OP_DEC);
  endfunction

  function automatic logic op_is_arith(input alu_op_e op);
    op_is_arith = (op == OP_ADD) || (op == OP_ADDC) || (op == OP_NADD) || (op == OP_SUB) ||
                  (op == OP_SUBC) || (op == OP_INC) || (op == OP_DEC);
  endfunction

  function automatic logic op_is_shift(input alu_op_e op);
    op_is_shift = (op == OP_SHR) || (op == OP_SRC) || (op == OP_SHL) || (op == OP_SLC);
  endfunction

  function automatic logic form_is_single(input alu_form_e form);
    form_is_single = (form == FORM_A) || (form == FORM_M);
  endfunction

  // ==========================================================================
  // Operation classification
  // ==========================================================================
  logic arith_op;
  logic shift_op;
  logic sub_mode;
  logic with_ripple;
  logic fixed_mem_op;
  logic unit_op;
  logic single_form;
  logic target_is_mem;
  logic swap_roles;
  logic known_op;

  assign arith_op     = op_is_arith(op_code);
  assign shift_op     = op_is_shift(op_code);
  assign sub_mode     = op_is_sub(op_code);
  assign with_ripple  = (op_code == OP_ADDC) || (op_code == OP_SUBC);
  assign fixed_mem_op = (op_code == OP_INC) || (op_code == OP_DEC) || (op_code == OP_CLEAR);
  assign unit_op      = (op_code == OP_INC) || (op_code == OP_DEC);
  assign single_form  = form_is_single(op_form);
  assign known_op     = arith_op || shift_op || (op_code == OP_CLEAR) || (op_code == OP_SWAP);

  // Swap always targets the working register; inc, dec and clear always memory
  assign target_is_mem = fixed_mem_op ||
                         ((op_code != OP_SWAP) && ((op_form == FORM_M) || (op_form == FORM_M_A)));

  // Forms whose minuend is the memory byte rather than the working register
  assign swap_roles = (((op_code == OP_SUB) || (op_code == OP_SUBC)) && (op_form == FORM_M_A)) ||
                      ((op_code == OP_NADD) && (op_form == FORM_A_M));

  // ==========================================================================
  // Operand selection
  // ==========================================================================
  logic [DATA_W-1:0] target_val;
  logic [DATA_W-1:0] second_val;
  logic [DATA_W-1:0] p_val;
  logic [DATA_W-1:0] q_val;
  logic [DATA_W-1:0] b_val;
  logic              carry_in;

  assign target_val = target_is_mem ? mem_rd_data : working_register_q;
  assign second_val = (op_form == FORM_A_I) ? imm_data : mem_rd_data;

  assign p_val = (unit_op || single_form) ? target_val :
                 swap_roles               ? mem_rd_data :
                                            working_register_q;

  assign q_val = unit_op     ? BYTE_ONE :
                 single_form ? BYTE_ZERO :
                 swap_roles  ? working_register_q :
                               second_val;

  // Subtraction adds the two's complement of the subtrahend
  assign b_val = sub_mode ? ~q_val : q_val;

  // Ripple-in: plain add 0, plain subtract 1, with-ripple add C or subtract C
  assign carry_in = !with_ripple ? sub_mode :
                    sub_mode     ? ~ripple_flag_q :
                                   ripple_flag_q;

  // ==========================================================================
  // Adder
  // ==========================================================================
  logic [DATA_W-1:0] sum_val;
  logic              sum_cout;
  logic              sum_nibble_cout;
  logic              sum_overflow;

  ripple_add8 u_add (
    .add_a           (p_val),
    .add_b           (b_val),
    .add_cin         (carry_in),
    .add_sum         (sum_val),
    .add_cout        (sum_cout),
    .add_nibble_cout (sum_nibble_cout),
    .add_overflow    (sum_overflow)
  );

  // ==========================================================================
  // Arithmetic flags
  // ==========================================================================
  logic arith_zero;
  logic arith_ripple;
  logic arith_nibble;

  assign arith_zero   = (sum_val == BYTE_ZERO);
  // Carry out is inverted on subtraction so the flag reads as a borrow
  assign arith_ripple = sum_cout ^ sub_mode;
  assign arith_nibble = sum_nibble_cout ^ sub_mode;

  // ==========================================================================
  // Shift unit
  // ==========================================================================
  logic [DATA_W-1:0] shift_val;
  logic              shift_ripple;
  logic              shift_right;

  assign shift_right = (op_code == OP_SHR) || (op_code == OP_SRC);

  assign shift_val = (op_code == OP_SHR) ? {1'b0, target_val[DATA_W-1:1]} :
                     (op_code == OP_SRC) ? {ripple_flag_q, target_val[DATA_W-1:1]} :
                     (op_code == OP_SHL) ? {target_val[DATA_W-2:0], 1'b0} :
                                           {target_val[DATA_W-2:0], ripple_flag_q};

  assign shift_ripple = shift_right ? target_val[0] :
                                      target_val[DATA_W-1];

  // ==========================================================================
  // Result selection
  // ==========================================================================
  logic [DATA_W-1:0] swap_val;
  logic [DATA_W-1:0] result_val;

  assign swap_val = {working_register_q[NIBBLE_W-1:0], working_register_q[DATA_W-1:NIBBLE_W]};

  assign result_val = arith_op              ? sum_val :
                      shift_op              ? shift_val :
                      (op_code == OP_SWAP)  ? swap_val :
                                              BYTE_ZERO;

  // ==========================================================================
  // Write enables
  // ==========================================================================
  logic do_op;
  logic wreg_write;
  logic mem_write;
  logic flags_all_write;
  logic ripple_only_write;

  assign do_op             = op_valid && known_op;
  assign wreg_write        = do_op && !target_is_mem;
  assign mem_write         = do_op && target_is_mem;
  assign flags_all_write   = do_op && arith_op;
  assign ripple_only_write = do_op && shift_op;

  // ==========================================================================
  // Direct loads: register load blocked by a register write, flag load by any accepted operation
  // ==========================================================================
  logic wreg_take;
  logic flag_take;

  assign wreg_take = wreg_load && !wreg_write;
  assign flag_take = flag_load && !do_op;

  // ==========================================================================
  // Next-state values
  // ==========================================================================
  logic [DATA_W-1:0] wreg_d;
  logic              zero_d;
  logic              ripple_d;
  logic              nibble_d;
  logic              range_d;

  // An operation wins over a simultaneous direct load
  assign wreg_d = wreg_write ? result_val :
                  wreg_take  ? wreg_load_data :
                               working_register_q;

  // Clear and swap fall through to hold; shifts touch only the ripple flag
  assign zero_d   = flags_all_write ? arith_zero :
                    flag_take       ? flag_load_data[FLAG_Z_POS] :
                                      zero_flag_q;

  assign ripple_d = flags_all_write   ? arith_ripple :
                    ripple_only_write ? shift_ripple :
                    flag_take         ? flag_load_data[FLAG_C_POS] :
                                        ripple_flag_q;

  assign nibble_d = flags_all_write ? arith_nibble :
                    flag_take       ? flag_load_data[FLAG_NIB_POS] :
                                      nibble_ripple_flag_q;

  assign range_d  = flags_all_write ? sum_overflow :
                    flag_take       ? flag_load_data[FLAG_RNG_POS] :
                                      signed_range_flag_q;

  // ==========================================================================
  // Working register
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      working_register_q <= WREG_RESET;
    end
    else
    begin
      working_register_q <= wreg_d;
    end
  end

  // ==========================================================================
  // Flag register
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      zero_flag_q          <= FLAG_RESET[FLAG_Z_POS];
      ripple_flag_q        <= FLAG_RESET[FLAG_C_POS];
      nibble_ripple_flag_q <= FLAG_RESET[FLAG_NIB_POS];
      signed_range_flag_q  <= FLAG_RESET[FLAG_RNG_POS];
    end
    else
    begin
      zero_flag_q          <= zero_d;
      ripple_flag_q        <= ripple_d;
      nibble_ripple_flag_q <= nibble_d;
      signed_range_flag_q  <= range_d;
    end
  end

  // ==========================================================================
  // Memory write-back and completion strobe
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      mem_wr_en_q   <= 1'b0;
      mem_wr_data_q <= BYTE_ZERO;
      op_done_q     <= 1'b0;
    end
    else
    begin
      mem_wr_en_q   <= mem_write;
      mem_wr_data_q <= mem_write ? result_val : mem_wr_data_q;
      op_done_q     <= do_op;
    end
  end

endmodule

//--- arith_shift_alu8_asserts.sv
// Port-level checks of the arithmetic and shift datapath
`timescale 1ns/1ps

module arith_shift_alu8_chk
  import arith_shift_alu8_pkg::*;
(
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              op_valid,
  input wire alu_op_e           op_code,
  input wire alu_form_e         op_form,
  input wire logic [DATA_W-1:0] imm_data,
  input wire logic [DATA_W-1:0] mem_rd_data,
  input wire logic [DATA_W-1:0] working_register_q,
  input wire logic              zero_flag_q,
  input wire logic              ripple_flag_q,
  input wire logic              nibble_ripple_flag_q,
  input wire logic              signed_range_flag_q,
  input wire logic              mem_wr_en_q,
  input wire logic [DATA_W-1:0] mem_wr_data_q,
  input wire logic              op_done_q
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  wire          known_op = op_valid && (op_code >= OP_ADD) && (op_code <= OP_SWAP);
  wire [7:0]    wreg     = working_register_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence take(alu_op_e c, alu_form_e f);
    op_valid && op_code == c && op_form == f;
  endsequence
  sequence take_any(alu_op_e c);
    op_valid && op_code == c;
  endsequence
  sequence flags_kept;
    $stable(zero_flag_q) && $stable(nibble_ripple_flag_q) && $stable(signed_range_flag_q);
  endsequence

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_done_pulse: assert property (known_op |=> op_done_q)
    else $error("op_done_q missing after an accepted operation");
  chk_refused_quiet: assert property (!known_op |=> !op_done_q && !mem_wr_en_q)
    else $error("activity without an accepted operation");
  chk_add_imm: assert property (take(OP_ADD, FORM_A_I) |=> wreg == $past(wreg) + $past(imm_data)
    && ripple_flag_q == ($past(wreg) > ~$past(imm_data))) else $error("immediate add wrong");
  chk_sub_borrow: assert property (take(OP_SUB, FORM_A_M) |=> wreg == $past(wreg) - $past(mem_rd_data)
    && ripple_flag_q == ($past(mem_rd_data) > $past(wreg))) else $error("subtract borrow wrong");
  chk_inc_write: assert property (take_any(OP_INC) |=> mem_wr_en_q && mem_wr_data_q == $past(mem_rd_data) + 8'h01
    && zero_flag_q == ($past(mem_rd_data) == 8'hFF)) else $error("increment wrong");
  chk_clear_keep: assert property (take_any(OP_CLEAR) |=>
    (mem_wr_en_q && mem_wr_data_q == 8'h00 && $stable(ripple_flag_q)) ##0 flags_kept) else $error("clear wrong");
  chk_right_shift: assert property (take(OP_SHR, FORM_A) |=>
    (wreg == {1'b0, $past(wreg[7:1])} && ripple_flag_q == $past(wreg[0])) ##0 flags_kept)
    else $error("right shift wrong");
  chk_slc_rotate: assert property (take(OP_SLC, FORM_A) |=> wreg == {$past(wreg[6:0]), $past(ripple_flag_q)}
    && ripple_flag_q == $past(wreg[7])) else $error("left rotate wrong");
  chk_swap_nibbles: assert property (take_any(OP_SWAP) |=> (wreg == {$past(wreg[3:0]), $past(wreg[7:4])}
    && !mem_wr_en_q && $stable(ripple_flag_q)) ##0 flags_kept) else $error("nibble swap wrong");
endmodule

bind arith_shift_alu8 arith_shift_alu8_chk u_chk (.clk(clk), .rstn(rstn), .op_valid(op_valid),
  .op_code(op_code), .op_form(op_form), .imm_data(imm_data), .mem_rd_data(mem_rd_data),
  .working_register_q(working_register_q), .zero_flag_q(zero_flag_q), .ripple_flag_q(ripple_flag_q),
  .nibble_ripple_flag_q(nibble_ripple_flag_q), .signed_range_flag_q(signed_range_flag_q),
  .mem_wr_en_q(mem_wr_en_q), .mem_wr_data_q(mem_wr_data_q), .op_done_q(op_done_q));

//--- alu_mem_model.sv
// One data-memory byte as seen by the datapath
`timescale 1ns/1ps

module alu_mem_model
  import arith_shift_alu8_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              preload,
  input  wire logic [DATA_W-1:0] preload_data,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_q;

  // Write lands one edge after the result, so the next read must wait a cycle
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_q <= wr_data;
    else if (preload)
      mem_q <= preload_data;
  end
  assign rd_data = mem_q;
endmodule

//--- tb_arith_shift_alu8.sv
// Self-checking bench for the arithmetic and shift datapath
`timescale 1ns/1ps

module tb_arith_shift_alu8
  import arith_shift_alu8_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, wreg_load = 1'b0, flag_load = 1'b0, preload = 1'b0;
  alu_op_e     op_code = OP_NOP;
  alu_form_e   op_form = FORM_A_I;
  logic [7:0]  imm_data = 8'h00, wreg_load_data = 8'h00, preload_data = 8'h00;
  logic [3:0]  flag_load_data = 4'h0;
  logic [7:0]  mem_rd_data, working_register_q, mem_wr_data_q, ea, em;
  logic        zero_flag_q, ripple_flag_q, nibble_ripple_flag_q, signed_range_flag_q, mem_wr_en_q, op_done_q, ew;
  logic [3:0]  ef, fl;
  int          num_errors = 0, n_tests = 0;
  wire  [3:0]  flags = {signed_range_flag_q, nibble_ripple_flag_q, ripple_flag_q, zero_flag_q};
  localparam logic [15:0] VEC [6] = '{16'h0000, 16'h010F, 16'h8080, 16'h7F01, 16'h3842, 16'hFFFF};

  always #10 clk = ~clk;

  arith_shift_alu8 dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code), .op_form(op_form),
    .imm_data(imm_data), .mem_rd_data(mem_rd_data), .wreg_load(wreg_load), .wreg_load_data(wreg_load_data),
    .flag_load(flag_load), .flag_load_data(flag_load_data), .working_register_q(working_register_q),
    .zero_flag_q(zero_flag_q), .ripple_flag_q(ripple_flag_q), .nibble_ripple_flag_q(nibble_ripple_flag_q),
    .signed_range_flag_q(signed_range_flag_q), .mem_wr_en_q(mem_wr_en_q), .mem_wr_data_q(mem_wr_data_q),
    .op_done_q(op_done_q));
  alu_mem_model mem (.clk(clk), .preload(preload), .preload_data(preload_data), .wr_en(mem_wr_en_q),
    .wr_data(mem_wr_data_q), .rd_data(mem_rd_data));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    begin
      n_tests++;
      if (got !== exp)
      begin
        num_errors++;
        $display("mismatch %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task automatic setup(input logic [7:0] a, input logic [7:0] m, input logic [3:0] f);
    begin
      @(negedge clk);
      {wreg_load, flag_load, preload} = 3'h7;
      {wreg_load_data, preload_data, flag_load_data} = {a, m, f};
      @(negedge clk);
      {wreg_load, flag_load, preload} = 3'h0;
    end
  endtask

  // Result is settled at the falling edge after the taking edge
  task automatic run_op(input alu_op_e op, input alu_form_e fm, input logic [7:0] im);
    begin
      @(negedge clk);
      {op_valid, op_code, op_form, imm_data} = {1'b1, op, fm, im};
      @(negedge clk);
      op_valid = 1'b0;
    end
  endtask

  function automatic logic legal(input alu_op_e op, input alu_form_e fm);
    case (op)
      OP_ADD, OP_SUB:           legal = fm inside {FORM_A_I, FORM_A_M, FORM_M_A};
      OP_ADDC, OP_SUBC:         legal = fm != FORM_A_I;
      OP_NADD:                  legal = fm inside {FORM_A_M, FORM_M_A};
      OP_INC, OP_DEC, OP_CLEAR: legal = fm == FORM_M;
      OP_SWAP:                  legal = fm == FORM_A;
      default:                  legal = fm inside {FORM_A, FORM_M};
    endcase
  endfunction

  task automatic predict(input alu_op_e op, input alu_form_e fm, input logic [7:0] a, m, input logic [3:0] f);
    logic [7:0] t, o, p, q, r;
    logic [8:0] s;
    logic [4:0] h;
    logic       sb, ci;
    begin
      ew = fm inside {FORM_M, FORM_M_A} || op inside {OP_INC, OP_DEC, OP_CLEAR};
      t = ew ? m : a;
      o = ew ? a : m;
      p = (op == OP_NADD) ? o : t;
      q = (fm == FORM_A_I) ? m : (fm inside {FORM_A_M, FORM_M_A}) ? ((op == OP_NADD) ? t : o) : 8'h00;
      q = (op inside {OP_INC, OP_DEC}) ? 8'h01 : q;
      sb = op inside {OP_NADD, OP_SUB, OP_SUBC, OP_DEC};
      ci = (op == OP_ADDC) ? f[1] : (op == OP_SUBC) ? ~f[1] : sb;
      q = sb ? ~q : q;
      s = p + q + ci;
      h = p[3:0] + q[3:0] + ci;
      r = s[7:0];
      ef = {(p[7] == q[7]) && (r[7] != p[7]), h[4] ^ sb, s[8] ^ sb, r == 8'h00};
      case (op)
        OP_SHR:   {r, ef} = {1'b0, t[7:1], f[3:2], t[0], f[0]};
        OP_SRC:   {r, ef} = {f[1], t[7:1], f[3:2], t[0], f[0]};
        OP_SHL:   {r, ef} = {t[6:0], 1'b0, f[3:2], t[7], f[0]};
        OP_SLC:   {r, ef} = {t[6:0], f[1], f[3:2], t[7], f[0]};
        OP_CLEAR: {r, ef} = {8'h00, f};
        OP_SWAP:  {r, ef} = {a[3:0], a[7:4], f};
        default:  ;
      endcase
      ea = ew ? a : r;
      em = r;
    end
  endtask

  task automatic wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check("wreg reset", WREG_RESET, working_register_q);
    check("flag reset", {4'h0, FLAG_RESET}, {4'h0, flags});
    check("strobe reset", 8'h00, {6'h00, mem_wr_en_q, op_done_q});
    check("wdata reset", BYTE_ZERO, mem_wr_data_q);
    for (int o = 1; o < 14; o++)
      for (int fi = 0; fi < 5; fi++)
        if (legal(alu_op_e'(o), alu_form_e'(fi)))
          for (int v = 0; v < 6; v++)
          begin
            fl = v[0] ? 4'hA : 4'h5;
            setup(VEC[v][15:8], VEC[v][7:0], fl);
            predict(alu_op_e'(o), alu_form_e'(fi), VEC[v][15:8], VEC[v][7:0], fl);
            run_op(alu_op_e'(o), alu_form_e'(fi), VEC[v][7:0]);
            check("wreg", ea, working_register_q);
            check("flags", {4'h0, ef}, {4'h0, flags});
            check("wr_en", {7'h00, ew}, {7'h00, mem_wr_en_q});
            if (ew)
              check("wdata", em, mem_wr_data_q);
            check("done", 8'h01, {7'h00, op_done_q});
          end
    for (int k = 0; k < 2; k++)
    begin
      setup(8'h5A, 8'h33, 4'hA);
      run_op(alu_op_e'(k ? 4'hE : 4'h0), FORM_A_M, 8'h11);
      check("refused wreg", 8'h5A, working_register_q);
      check("refused flags", 8'h0A, {4'h0, flags});
      check("refused strobes", 8'h00, {6'h00, mem_wr_en_q, op_done_q});
    end
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule
